/* File: design/wdpd_pkg.sv */
`default_nettype none
package wdpd_pkg;
  // register offsets
  localparam logic [7:0] WDPD_ADDR_COUNT_FIRST  = 8'hc2;
  localparam logic [7:0] WDPD_ADDR_COUNT_SECOND = 8'hc3;
  localparam logic [7:0] WDPD_ADDR_CTRL_HIGH    = 8'hc1;
  localparam logic [7:0] WDPD_ADDR_FLAGS        = 8'hc4;
  // timer_control_high fields
  localparam int WDPD_BIT_HALT_RUN  = 7;
  localparam int WDPD_BIT_SEL_LO    = 4;
  localparam int WDPD_BIT_STOP_DIS  = 3;
  localparam logic [7:0] WDPD_CTRL_RESET  = 8'h98;
  localparam logic [7:0] WDPD_UPPER_MASK  = 8'hf8;
  // flags register fields
  localparam int WDPD_BIT_WD_FLAG   = 0;
  localparam int WDPD_BIT_SR_FLAG   = 1;
  // prescaler and glitch filter
  localparam int WDPD_PRESCALE      = 64;
  localparam int WDPD_FILTER_LEN    = 3;
  // restart vector
  localparam logic [15:0] WDPD_RESTART_VEC = 16'h0020;
  // core commands
  localparam logic [7:0] WDPD_OP_HALT = 8'h7f;
  localparam logic [7:0] WDPD_OP_STOP = 8'h6f;
  typedef enum {WDPD_RUN, WDPD_HALTED, WDPD_STOPPED} wdpd_mode_t;
endpackage
`default_nettype wire

/* File: design/wdpd_top.sv */
// Strobed register access is this design's own decision.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RULE_01) 16-bit one-shot watchdog resets on terminal count
// (RULE_02) watchdog advances once per 64 oscillator clocks
// (RULE_03) run/halt time-out vectors 0020h, sets flag
// (RULE_04) refresh reloads count from time-select field
// (RULE_05) disable only first instruction; stops in stop
// (RULE_06) time-out beats a coincident refresh
// (RULE_07) reset clears flags; events set them
// (RULE_08) reads leave flags; software clears by write
// (RULE_09) upper five control bits writable first instruction
// (RULE_10) time-select encodes disabled through 8,388,608 clocks
// (RULE_11) bit 7 keeps watchdog running in halt
// (RULE_12) bit 3 set makes stop a no-op; the code still sets sr_flag_reg on that stop opcode
// (RULE_13) software writes zero to reserved low bits
// (RULE_14) halt opcode gates cpu clock, timers run
// (RULE_15) interrupt ends halt, resumes after halt
// (RULE_16) reset or time-out ends halt at 0020h
// (RULE_17) enabled stop opcode turns off oscillator, clock
// (RULE_18) stop ends by reset or recovery, flag set
// (RULE_19) held low recovery pin restarts after delay
// (RULE_20) pin recovery keeps control register values
// (RULE_21) internal clock is filtered oscillator divided two
// (RULE_22) refresh also clears the prescaler
module wdpd_top #(
  parameter int POR_DELAY_CYCLES  = 64,
  parameter int RECOVERY_MIN_LOW  = 4
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [7:0]  reg_rdata_out,
  // core instruction interface
  input  wire logic        instr_exec_in,
  input  wire logic [7:0]  instr_opcode_in,
  input  wire logic        refresh_in,
  input  wire logic        interrupt_in,
  input  wire logic        recovery_select_in,
  // pins
  input  wire logic        oscillator_input_pin_in,
  input  wire logic        recovery_pin_in,
  // control outputs
  output logic             oscillator_enable_out,
  output logic             cpu_clock_enable_out,
  output logic             internal_clock_out,
  output logic             core_restart_out,
  output logic      [15:0] restart_vector_out,
  output logic             halted_out,
  output logic             stopped_out
);

  ////////////////////////////////////////////////////////////////////////////////
  localparam int WDPD_W = 8;
  logic [1:0]            rec_sync_reg;
  logic [1:0]            osc_sync_reg;
  logic [7:0]            ctrl_reg;
  logic                  first_instr_reg;
  logic [15:0]           count_reg;
  logic [5:0]            presc_reg;
  logic [1:0]            ext_reg;
  logic                  wd_flag_reg;
  logic                  sr_flag_reg;
  logic [WDPD_W-1:0]     low_cnt_reg;
  logic [15:0]           por_cnt_reg;
  logic                  por_busy_reg;
  logic [2:0]            filt_reg;
  logic                  filt_clk_reg;
  logic                  div_reg;
  wdpd_pkg::wdpd_mode_t  mode_reg;

  logic [2:0]  sel;
  logic        tick;
  logic        timeout;
  logic        wd_live;
  logic        is_halt;
  logic        is_stop;
  logic        wr_ctrl;
  logic        wr_flags;
  logic        recover;
  logic [15:0] reload_cnt;
  logic [1:0]  reload_ext;

  assign sel     = ctrl_reg[wdpd_pkg::WDPD_BIT_SEL_LO +: 3];
  assign is_halt = instr_exec_in && instr_opcode_in == wdpd_pkg::WDPD_OP_HALT;
  assign is_stop = instr_exec_in && instr_opcode_in == wdpd_pkg::WDPD_OP_STOP;
  assign wr_ctrl  = reg_write_in && reg_addr_in == wdpd_pkg::WDPD_ADDR_CTRL_HIGH;
  assign wr_flags = reg_write_in && reg_addr_in == wdpd_pkg::WDPD_ADDR_FLAGS;

  ////////////////////////////////////////////////////////////////////////////////
  // reload values: 65,536 * 2^(sel-1) clocks / 64 for sel 001-110 (1024 ticks at sel 001); sel 111 gives 8,388,608 clocks
  // count is 16 bits; the two extension bits reach the longest setting, sel 111
  always_comb begin
    reload_cnt = 16'h0000;
    reload_ext = 2'h0;
    case (sel) // [RULE_10]
      3'h1:    reload_cnt = 16'h0400;
      3'h2:    reload_cnt = 16'h0800;
      3'h3:    reload_cnt = 16'h1000;
      3'h4:    reload_cnt = 16'h2000;
      3'h5:    reload_cnt = 16'h4000;
      3'h6:    reload_cnt = 16'h8000;
      3'h7:    reload_ext = 2'h2;
      default: reload_cnt = 16'h0000;
    endcase
  end

  // halt-activity bit gates the watchdog while halted
  assign wd_live = sel != 3'h0 && mode_reg != wdpd_pkg::WDPD_STOPPED // [RULE_05]
                   && (mode_reg != wdpd_pkg::WDPD_HALTED
                       || ctrl_reg[wdpd_pkg::WDPD_BIT_HALT_RUN]); // [RULE_11]
  assign tick    = wd_live && presc_reg == 6'(wdpd_pkg::WDPD_PRESCALE - 1); // [RULE_02]
  assign timeout = tick && count_reg == 16'h0001 && ext_reg == 2'h0; // [RULE_01]
  assign recover = mode_reg == wdpd_pkg::WDPD_STOPPED && recovery_select_in
                   && low_cnt_reg >= WDPD_W'(RECOVERY_MIN_LOW); // [RULE_19]

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_sync_reg <= 2'h3;
      osc_sync_reg <= 2'h0;
    end else begin
      rec_sync_reg <= {rec_sync_reg[0], recovery_pin_in};
      osc_sync_reg <= {osc_sync_reg[0], oscillator_input_pin_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register; stop recovery does not reinitialise it
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg        <= wdpd_pkg::WDPD_CTRL_RESET;
      first_instr_reg <= 1'b1;
    end else begin
      if (instr_exec_in)
        first_instr_reg <= 1'b0; // [RULE_09]
      // reserved low bits forced to zero whatever software writes
      if (wr_ctrl && first_instr_reg)
        ctrl_reg <= reg_wdata_in & wdpd_pkg::WDPD_UPPER_MASK; // [RULE_09] [RULE_13]
    end
  end // [RULE_20]

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog prescaler and counter
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_reg <= 6'h00;
      count_reg <= 16'h0400;
      ext_reg   <= 2'h0;
    end else if (timeout) begin // [RULE_06]
      presc_reg <= 6'h00;
      count_reg <= reload_cnt;
      ext_reg   <= reload_ext;
    end else if (refresh_in) begin
      presc_reg <= 6'h00; // [RULE_22]
      count_reg <= reload_cnt; // [RULE_04]
      ext_reg   <= reload_ext;
    end else if (wd_live) begin
      presc_reg <= presc_reg + 6'h01;
      if (tick) begin
        count_reg <= count_reg - 16'h0001;
        if (count_reg == 16'h0000)
          ext_reg <= ext_reg - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags; hardware set wins over a software clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_flag_reg <= 1'b0; // [RULE_07]
      sr_flag_reg <= 1'b0;
    end else begin
      if (timeout)
        wd_flag_reg <= 1'b1; // [RULE_03] [RULE_07]
      else if (wr_flags && !reg_wdata_in[wdpd_pkg::WDPD_BIT_WD_FLAG])
        wd_flag_reg <= 1'b0; // [RULE_08]
      if (is_stop)
        sr_flag_reg <= 1'b1; // [RULE_07]
      else if (wr_flags && !reg_wdata_in[wdpd_pkg::WDPD_BIT_SR_FLAG])
        sr_flag_reg <= 1'b0; // [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power modes
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      mode_reg <= wdpd_pkg::WDPD_RUN;
    else
      case (mode_reg)
        wdpd_pkg::WDPD_RUN:
          if (is_halt)
            mode_reg <= wdpd_pkg::WDPD_HALTED; // [RULE_14]
          else if (is_stop && !ctrl_reg[wdpd_pkg::WDPD_BIT_STOP_DIS])
            mode_reg <= wdpd_pkg::WDPD_STOPPED; // [RULE_12] [RULE_17]
        wdpd_pkg::WDPD_HALTED:
          if (interrupt_in || timeout)
            mode_reg <= wdpd_pkg::WDPD_RUN; // [RULE_15] [RULE_16]
        wdpd_pkg::WDPD_STOPPED:
          if (recover)
            mode_reg <= wdpd_pkg::WDPD_RUN; // [RULE_18]
        default: mode_reg <= wdpd_pkg::WDPD_RUN;
      endcase
  end

  // recovery pin low-time counter, saturating
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      low_cnt_reg <= '0;
    else if (mode_reg != wdpd_pkg::WDPD_STOPPED || rec_sync_reg[1])
      low_cnt_reg <= '0;
    else if (low_cnt_reg != '1)
      low_cnt_reg <= low_cnt_reg + WDPD_W'(1); // [RULE_19]
  end

  // power-on delay after recovery, then restart at the vector
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_busy_reg <= 1'b0;
      por_cnt_reg  <= 16'h0000;
    end else if (recover) begin
      por_busy_reg <= 1'b1;
      por_cnt_reg  <= 16'(POR_DELAY_CYCLES - 1);
    end else if (por_busy_reg) begin
      if (por_cnt_reg == 16'h0000)
        por_busy_reg <= 1'b0;
      else
        por_cnt_reg <= por_cnt_reg - 16'h0001; // [RULE_19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // glitch filter then divide by two; pulses shorter than the filter are dropped
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      filt_reg     <= 3'h0;
      filt_clk_reg <= 1'b0;
      div_reg      <= 1'b0;
    end else begin
      filt_reg <= {filt_reg[1:0], osc_sync_reg[1]};
      if (filt_reg == 3'h7 && !filt_clk_reg) begin
        filt_clk_reg <= 1'b1;
        div_reg      <= ~div_reg; // [RULE_21]
      end else if (filt_reg == 3'h0)
        filt_clk_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oscillator_enable_out <= 1'b1;
      cpu_clock_enable_out  <= 1'b1;
      internal_clock_out    <= 1'b0;
      core_restart_out      <= 1'b0;
      restart_vector_out    <= wdpd_pkg::WDPD_RESTART_VEC;
      halted_out            <= 1'b0;
      stopped_out           <= 1'b0;
    end else begin
      oscillator_enable_out <= mode_reg != wdpd_pkg::WDPD_STOPPED || recover
                               || por_busy_reg; // [RULE_17]
      cpu_clock_enable_out  <= mode_reg == wdpd_pkg::WDPD_RUN && !por_busy_reg; // [RULE_14]
      internal_clock_out    <= div_reg && mode_reg != wdpd_pkg::WDPD_STOPPED;
      core_restart_out      <= timeout
                               || (por_busy_reg && por_cnt_reg == 16'h0000); // [RULE_03] [RULE_18]
      restart_vector_out    <= wdpd_pkg::WDPD_RESTART_VEC; // [RULE_16]
      halted_out            <= mode_reg == wdpd_pkg::WDPD_HALTED;
      stopped_out           <= mode_reg == wdpd_pkg::WDPD_STOPPED;
    end
  end

  // read data one cycle after the strobe; reads have no side effect
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_read_in)
      case (reg_addr_in)
        wdpd_pkg::WDPD_ADDR_COUNT_FIRST:  reg_rdata_out <= count_reg[7:0];
        wdpd_pkg::WDPD_ADDR_COUNT_SECOND: reg_rdata_out <= count_reg[15:8];
        wdpd_pkg::WDPD_ADDR_CTRL_HIGH:    reg_rdata_out <= ctrl_reg;
        wdpd_pkg::WDPD_ADDR_FLAGS:        reg_rdata_out <= {6'h00, sr_flag_reg, wd_flag_reg}; // [RULE_08]
        default:                          reg_rdata_out <= 8'h00;
      endcase
    else
      reg_rdata_out <= 8'h00;
  end

endmodule
`default_nettype wire

/* File: sim/wdpd_assertions.sv */
`default_nettype none
module wdpd_checker #(
  parameter int POR_DELAY_CYCLES = 64,
  parameter int RECOVERY_MIN_LOW = 4
) (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        instr_exec_in,
  input wire logic [7:0]  instr_opcode_in,
  input wire logic        interrupt_in,
  input wire logic        recovery_select_in,
  input wire logic        recovery_pin_in,
  input wire logic        oscillator_enable_out,
  input wire logic        cpu_clock_enable_out,
  input wire logic        internal_clock_out,
  input wire logic        core_restart_out,
  input wire logic [15:0] restart_vector_out,
  input wire logic        halted_out,
  input wire logic        stopped_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // wake-up bound follows the power-on delay plus pin filtering margin
  localparam int WAKE_MAX = POR_DELAY_CYCLES + 8;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence halt_cmd;
    instr_exec_in && instr_opcode_in == 8'h7f && !halted_out && !stopped_out;
  endsequence
  // pin idle or not armed: no wake-up may happen
  sequence pin_idle8;
    (stopped_out && (recovery_pin_in || !recovery_select_in))[*8];
  endsequence
  vector_fixed_a: assert property (core_restart_out |-> restart_vector_out == 16'h0020)
    else $error("restart vector wrong");
  restart_pulse_a: assert property (core_restart_out |=> !core_restart_out)
    else $error("restart longer than one cycle");
  halt_entry_a: assert property (halt_cmd |-> ##[1:3] halted_out)
    else $error("halt not entered");
  halt_osc_a: assert property (halted_out |-> oscillator_enable_out)
    else $error("oscillator off in halt");
  halt_cpu_a: assert property ($rose(halted_out) |-> ##[0:1] !cpu_clock_enable_out)
    else $error("cpu clock runs in halt");
  irq_exit_a: assert property (halted_out && interrupt_in |-> ##[1:3] !halted_out)
    else $error("interrupt did not end halt");
  stop_osc_a: assert property ($rose(stopped_out) |-> ##[0:2] !oscillator_enable_out)
    else $error("oscillator runs in stop");
  stop_hold_a: assert property (pin_idle8 |=> stopped_out)
    else $error("stop left without recovery");
  wake_restart_a: assert property ($fell(stopped_out) |-> ##[0:WAKE_MAX] core_restart_out)
    else $error("no restart after recovery");
  clk_div_a: assert property ($changed(internal_clock_out) |=> $stable(internal_clock_out))
    else $error("internal clock not divided");
endmodule
bind wdpd_top wdpd_checker #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES),
  .RECOVERY_MIN_LOW(RECOVERY_MIN_LOW)) chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .instr_exec_in(instr_exec_in), .instr_opcode_in(instr_opcode_in),
  .interrupt_in(interrupt_in), .recovery_select_in(recovery_select_in),
  .recovery_pin_in(recovery_pin_in), .oscillator_enable_out(oscillator_enable_out),
  .cpu_clock_enable_out(cpu_clock_enable_out), .internal_clock_out(internal_clock_out),
  .core_restart_out(core_restart_out), .restart_vector_out(restart_vector_out),
  .halted_out(halted_out), .stopped_out(stopped_out));
`default_nettype wire

/* File: sim/wdpd_bench.sv */
`default_nettype none
module wdpd_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in, rst_n_in, wr_s, rd_s, rsel, rpin, rd_pend;
  logic [7:0]  addr, wdata, rdata, op;
  logic        exec, refresh, irq, osc, osc_en, cpu_en, iclk, restart, halted, stopped;
  logic [7:0]  opcode;
  logic [15:0] vec;
  int          n_fail, n_tests, seed, cyc;
  logic [7:0]  exp_q[$];
  string       nm_q[$];
  wdpd_top #(.POR_DELAY_CYCLES(4), .RECOVERY_MIN_LOW(4)) dut_u (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_rdata_out(rdata), .instr_exec_in(exec),
    .instr_opcode_in(opcode), .refresh_in(refresh), .interrupt_in(irq),
    .recovery_select_in(rsel), .oscillator_input_pin_in(osc), .recovery_pin_in(rpin),
    .oscillator_enable_out(osc_en), .cpu_clock_enable_out(cpu_en),
    .internal_clock_out(iclk), .core_restart_out(restart), .restart_vector_out(vec),
    .halted_out(halted), .stopped_out(stopped));
  wdpd_core_model core_u (.clock_in(clock_in), .osc_enable_in(osc_en), .exec_out(exec),
    .opcode_out(opcode), .refresh_out(refresh), .interrupt_out(irq), .osc_pin_out(osc));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask
  // the expectation is queued; the watcher below compares it
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clock_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
  endtask
  task automatic wait_restart(input int lim);
    cyc = 0;
    while (restart !== 1'b1 && cyc < lim) begin
      @(negedge clock_in);
      cyc++;
    end
  endtask
  always @(posedge clock_in) rd_pend <= rd_s;
  // read data stands only in the cycle after the strobe
  always @(negedge clock_in) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0)
      chk(nm_q.pop_front(), {8'h00, rdata}, {8'h00, exp_q.pop_front()});
  end
  initial begin
    #(50 * 80000);
    n_fail++;
    end_sim();
  end
  initial begin
    {rst_n_in, wr_s, rd_s, rsel, rd_pend} = 5'h00;
    rpin = 1'b1;
    {addr, wdata} = 16'h0000;
    {n_fail, n_tests, seed} = {32'd0, 32'd0, 32'd1350};
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd("ctrl", 8'hc1, 8'h98);
    rd("count_hi", 8'hc3, 8'h04);
    rd("flags", 8'hc4, 8'h00);
    rd("unmapped", 8'h55, 8'h00);
    wr(8'hc1, 8'h90);
    op = 8'($random(seed));
    if (op == 8'h7f || op == 8'h6f)
      op = 8'h00;
    core_u.run_op(op);
    wr(8'hc1, 8'($random(seed)) & 8'hf8);
    rd("ctrl_locked", 8'hc1, 8'h90);
    $display("test reset_and_lock done");
    core_u.run_op(8'h7f);
    repeat (3) @(negedge clock_in);
    chk("halted", 16'(halted), 16'h0001);
    chk("cpu_en", 16'(cpu_en), 16'h0000);
    core_u.service_irq();
    repeat (3) @(negedge clock_in);
    chk("halted", 16'(halted), 16'h0000);
    $display("test halt done");
    @(posedge clock_in);
    rsel <= 1'b1;
    core_u.run_op(8'h6f);
    repeat (24) @(negedge clock_in);
    chk("stopped", 16'(stopped), 16'h0001);
    chk("osc_en", 16'(osc_en), 16'h0000);
    @(posedge clock_in);
    rpin <= 1'b0;
    wait_restart(60);
    chk("wake", 16'(cyc < 60), 16'h0001);
    chk("vector", vec, 16'h0020);
    @(posedge clock_in);
    rpin <= 1'b1;
    rd("flags", 8'hc4, 8'h02);
    rd("ctrl_kept", 8'hc1, 8'h90);
    rd("flags", 8'hc4, 8'h02);
    wr(8'hc4, 8'h00);
    rd("flags", 8'hc4, 8'h00);
    $display("test stop done");
    core_u.refresh_wd();
    rd("count_hi", 8'hc3, 8'h04);
    wait_restart(70000);
    chk("wd_period", 16'(cyc >= 65520 && cyc <= 65540), 16'h0001);
    rd("flags", 8'hc4, 8'h01);
    $display("test watchdog done");
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd("flags", 8'hc4, 8'h00);
    core_u.run_op(8'h6f);
    repeat (4) @(negedge clock_in);
    chk("stop_noop", 16'(stopped), 16'h0000);
    rd("flags", 8'hc4, 8'h02);
    repeat (4) @(posedge clock_in);
    $display("test stop_gate done");
    end_sim();
  end
endmodule
`default_nettype wire

/* File: sim/wdpd_core_model.sv */
`default_nettype none
module wdpd_core_model (
  input  wire logic       clock_in,
  input  wire logic       osc_enable_in,
  output var  logic       exec_out,
  output var  logic [7:0] opcode_out,
  output var  logic       refresh_out,
  output var  logic       interrupt_out,
  output var  logic       osc_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg;
  initial begin
    {exec_out, refresh_out, interrupt_out, osc_pin_out} = 4'h0;
    opcode_out = 8'h00;
    div_reg = 2'h0;
  end
  // slow crystal so the three-sample filter passes it; still when switched off
  always @(posedge clock_in) begin
    div_reg <= div_reg + 2'h1;
    if (osc_enable_in && div_reg == 2'h3)
      osc_pin_out <= !osc_pin_out;
  end
  task automatic run_op(input logic [7:0] op);
    @(posedge clock_in);
    exec_out <= 1'b1;
    opcode_out <= op;
    @(posedge clock_in);
    exec_out <= 1'b0;
    opcode_out <= ~op;
  endtask
  task automatic refresh_wd;
    @(posedge clock_in);
    refresh_out <= 1'b1;
    @(posedge clock_in);
    refresh_out <= 1'b0;
  endtask
  task automatic service_irq;
    @(posedge clock_in);
    interrupt_out <= 1'b1;
    repeat (2) @(posedge clock_in);
    interrupt_out <= 1'b0;
  endtask
endmodule
`default_nettype wire
